/* File: design/pec_counters.sv */
/*
 * four event counters with per-cycle increment limits and thresholding,
 * plus cycle accounting that files every cycle under one category.
 * assumes all event and stall inputs are synchronous to sys_clk and that
 * software reads count_q directly; control comes in as plain ports.
 */
`timescale 1ns/100ps
`default_nettype none

module pec_counters #(
    parameter int NUM_CTR = pec_pkg::PEC_NUM_CTR,
    parameter int NUM_WIDE = pec_pkg::PEC_NUM_WIDE,
    parameter int CTR_W = pec_pkg::PEC_CTR_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // per-counter control
    input wire logic [NUM_CTR-1:0] ctr_en,
    input wire logic [NUM_CTR-1:0] ctr_clr,
    input wire pec_pkg::pec_ev_sel_t ctr_sel [NUM_CTR],
    input wire logic [pec_pkg::PEC_INC_W-1:0] ctr_thr [NUM_CTR],
    // event sources
    input wire logic ev_itb_miss,
    input wire logic ev_dtb_miss,
    input wire logic ev_br_mispred,
    input wire logic [1:0] ev_dc_miss_cnt,
    input wire logic [pec_pkg::PEC_INC_W-1:0] ev_retired_cnt,
    input wire logic [pec_pkg::PEC_INC_W-1:0] ev_mrq_live,
    // back-end flush causes
    input wire logic fl_br_mispred,
    input wire logic fl_advanced_load_table,
    input wire logic fl_serialize,
    input wire logic fl_ctrl_spec_fail,
    input wire logic fl_memory_to_integer_unit_bypass,
    input wire logic fl_exception,
    // data access causes
    input wire logic st_mem_operand,
    input wire logic fl_l1d_way_mispred,
    input wire logic fl_data_translation_cache,
    // scoreboard causes
    input wire logic st_nonload_operand,
    input wire logic fl_fp,
    // register stack spill and fill
    input wire logic st_register_stack_engine,
    // issue limit causes
    input wire logic st_issue_stop,
    input wire logic st_port_oversub,
    input wire logic st_issue_asym,
    // instruction access causes
    input wire logic st_l1i_miss,
    input wire logic st_instruction_translation_buffer,
    // taken branch bubble
    input wire logic st_taken_branch,
    // results
    output logic [CTR_W-1:0] count_q [NUM_CTR],
    output pec_pkg::pec_cat_t acct_cat_q
);
    import pec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // cause grouping
    ////////////////////////////////////////////////////////////////////////

    // raw reason per category, before priority
    logic be_flush_raw;
    logic data_acc_raw;
    logic sb_dep_raw;
    logic issue_lim_raw;
    logic inst_acc_raw;

    // all back-end flush causes folded together
    assign be_flush_raw = fl_br_mispred | fl_advanced_load_table
        | fl_serialize | fl_ctrl_spec_fail
        | fl_memory_to_integer_unit_bypass | fl_exception;

    // memory operand waits and memory-side flushes
    assign data_acc_raw = st_mem_operand | fl_l1d_way_mispred
        | fl_data_translation_cache;

    // non-load producer waits, fp flushes included
    assign sb_dep_raw = st_nonload_operand | fl_fp;

    // dispersal breaks
    assign issue_lim_raw = st_issue_stop | st_port_oversub
        | st_issue_asym;

    // fetch stalls
    assign inst_acc_raw = st_l1i_miss
        | st_instruction_translation_buffer;

    ////////////////////////////////////////////////////////////////////////
    // cycle accounting
    ////////////////////////////////////////////////////////////////////////

    // next category; later pipe stage checked first so it wins overlaps
    pec_cat_t acct_cat_d;

    always_comb begin
        if (be_flush_raw) begin
            acct_cat_d = PEC_CAT_BE_FLUSH;
        end else if (data_acc_raw) begin
            acct_cat_d = PEC_CAT_DATA_ACC;
        end else if (sb_dep_raw) begin
            acct_cat_d = PEC_CAT_SB_DEP;
        end else if (st_register_stack_engine) begin
            acct_cat_d = PEC_CAT_REG_STACK;
        end else if (issue_lim_raw) begin
            acct_cat_d = PEC_CAT_ISSUE_LIM;
        end else if (inst_acc_raw) begin
            acct_cat_d = PEC_CAT_INST_ACC;
        end else if (st_taken_branch) begin
            acct_cat_d = PEC_CAT_TAKEN_BR;
        end else begin
            // nothing holds the back end: a useful cycle
            acct_cat_d = PEC_CAT_UNSTALLED;
        end
    end

    // one-hot register: exactly one category per cycle by construction
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acct_cat_q <= PEC_CAT_UNSTALLED;
        end else begin
            acct_cat_q <= acct_cat_d;
        end
    end

    // single-cycle flags derived from the registered category
    logic cat_be_flush;
    logic cat_data_acc;
    logic cat_sb_dep;
    logic cat_inst_acc;
    logic cat_pipe_flush;
    logic cat_memory;
    logic cat_depend;
    logic cat_unstalled;

    // decode the category into plain and combined events
    always_comb begin
        cat_be_flush = 1'b0;
        cat_data_acc = 1'b0;
        cat_sb_dep = 1'b0;
        cat_inst_acc = 1'b0;
        cat_pipe_flush = 1'b0;
        cat_memory = 1'b0;
        cat_depend = 1'b0;
        cat_unstalled = 1'b0;
        case (acct_cat_q)
            PEC_CAT_BE_FLUSH: begin
                cat_be_flush = 1'b1;
                cat_pipe_flush = 1'b1;
            end
            PEC_CAT_DATA_ACC: begin
                cat_data_acc = 1'b1;
                cat_memory = 1'b1;
            end
            PEC_CAT_SB_DEP: begin
                cat_sb_dep = 1'b1;
                cat_depend = 1'b1;
            end
            PEC_CAT_REG_STACK: begin
                cat_memory = 1'b1;
            end
            PEC_CAT_ISSUE_LIM: begin
                cat_depend = 1'b1;
            end
            PEC_CAT_INST_ACC: begin
                cat_inst_acc = 1'b1;
                cat_unstalled = 1'b1;
            end
            PEC_CAT_TAKEN_BR: begin
                cat_pipe_flush = 1'b1;
            end
            PEC_CAT_UNSTALLED: begin
                cat_unstalled = 1'b1;
            end
            default: begin
                // unreachable codes count nothing
                cat_be_flush = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // event staging
    ////////////////////////////////////////////////////////////////////////

    // events registered so that they line up with acct_cat_q
    logic itb_miss_q;
    logic dtb_miss_q;
    logic br_mispred_q;
    logic [PEC_INC_W-1:0] dc_miss_q;
    logic [PEC_INC_W-1:0] retired_q;
    logic [PEC_INC_W-1:0] mrq_live_q;
    logic [PEC_INC_W-1:0] dc_miss_d;

    // a third miss in one cycle cannot happen; clip defensively
    assign dc_miss_d = ({1'b0, ev_dc_miss_cnt} > PEC_DC_MISS_MAX)
        ? PEC_DC_MISS_MAX : {1'b0, ev_dc_miss_cnt};

    // stage all sources one cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            itb_miss_q <= 1'b0;
            dtb_miss_q <= 1'b0;
            br_mispred_q <= 1'b0;
            dc_miss_q <= PEC_INC_ZERO;
            retired_q <= PEC_INC_ZERO;
            mrq_live_q <= PEC_INC_ZERO;
        end else begin
            // one-bit sources: never more than one per cycle
            itb_miss_q <= ev_itb_miss;
            dtb_miss_q <= ev_dtb_miss;
            br_mispred_q <= ev_br_mispred;
            dc_miss_q <= dc_miss_d;
            retired_q <= ev_retired_cnt;
            mrq_live_q <= ev_mrq_live;
        end
    end

    // per-event occurrence this cycle, indexed by event code
    logic [PEC_INC_W-1:0] ev_val [16];

    // single-occurrence and duration events widen a bit to a count of one
    always_comb begin
        ev_val[PEC_EV_CYCLES] = PEC_INC_ONE;
        ev_val[PEC_EV_RETIRED] = retired_q;
        ev_val[PEC_EV_DC_MISS] = dc_miss_q;
        ev_val[PEC_EV_MRQ_LIVE] = mrq_live_q;
        ev_val[PEC_EV_ITB_MISS] = {2'b00, itb_miss_q};
        ev_val[PEC_EV_DTB_MISS] = {2'b00, dtb_miss_q};
        ev_val[PEC_EV_BR_MISPRED] = {2'b00, br_mispred_q};
        ev_val[PEC_EV_BE_FLUSH] = {2'b00, cat_be_flush};
        ev_val[PEC_EV_DATA_ACC] = {2'b00, cat_data_acc};
        ev_val[PEC_EV_SB_DEP] = {2'b00, cat_sb_dep};
        ev_val[PEC_EV_INST_ACC] = {2'b00, cat_inst_acc};
        ev_val[PEC_EV_PIPE_FLUSH] = {2'b00, cat_pipe_flush};
        ev_val[PEC_EV_MEMORY] = {2'b00, cat_memory};
        ev_val[PEC_EV_DEPEND] = {2'b00, cat_depend};
        ev_val[PEC_EV_UNSTALLED] = {2'b00, cat_unstalled};
        ev_val[PEC_EV_NONE] = PEC_INC_ZERO;
    end

    ////////////////////////////////////////////////////////////////////////
    // counters
    ////////////////////////////////////////////////////////////////////////

    // the low NUM_WIDE counters take up to seven, the rest clip at three;
    // clipping loses counts on a narrow counter, so software must pick
    // a wide counter for bursts above three
    for (genvar c = 0; c < NUM_CTR; c++) begin : g_ctr
        logic [PEC_INC_W-1:0] lim;
        logic [PEC_INC_W-1:0] raw;
        logic [PEC_INC_W-1:0] clipped;
        logic [PEC_INC_W-1:0] inc;

        // per-counter ceiling on one cycle's count
        assign lim = (c < NUM_WIDE) ? PEC_WIDE_MAX
            : PEC_NARROW_MAX;

        // selected event value
        assign raw = ev_val[ctr_sel[c]];

        // clip to what this counter can absorb
        assign clipped = (raw > lim) ? lim : raw;

        // threshold turns the count into a one-per-cycle exceed flag
        always_comb begin
            if (ctr_thr[c] != PEC_INC_ZERO) begin
                inc = (clipped > ctr_thr[c])
                    ? PEC_INC_ONE : PEC_INC_ZERO;
            end else begin
                inc = clipped;
            end
        end

        // counter: clear wins and drops that cycle's count, else add; the add wraps modulo 2^CTR_W
        // so any excess past all-ones lands in the wrapped value
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                count_q[c] <= PEC_CTR_RST;
            end else if (ctr_clr[c]) begin
                count_q[c] <= PEC_CTR_RST;
            end else if (ctr_en[c]) begin
                count_q[c] <= count_q[c]
                    + {{(CTR_W-PEC_INC_W){1'b0}}, inc};
            end
        end
    end

endmodule : pec_counters

`default_nettype wire

/* File: design/pec_pkg.sv */
/*
 * constants and types shared by the performance event counter block:
 * counter geometry, per-cycle limits, event codes, accounting categories.
 * assumes a single core clock and no software-visible register map.
 */
`default_nettype none

package pec_pkg;

    // counter geometry
    localparam int PEC_NUM_CTR = 4;
    localparam int PEC_NUM_WIDE = 2;
    localparam int PEC_CTR_W = 32;
    localparam int PEC_INC_W = 3;
    localparam int PEC_SEL_W = 4;
    localparam int PEC_CAT_N = 8;

    // reset and per-cycle limits
    localparam logic [PEC_CTR_W-1:0] PEC_CTR_RST = 32'h0000_0000;
    localparam logic [PEC_INC_W-1:0] PEC_NARROW_MAX = 3'h3;
    localparam logic [PEC_INC_W-1:0] PEC_WIDE_MAX = 3'h7;
    localparam logic [PEC_INC_W-1:0] PEC_DC_MISS_MAX = 3'h2;
    localparam logic [PEC_INC_W-1:0] PEC_INC_ZERO = 3'h0;
    localparam logic [PEC_INC_W-1:0] PEC_INC_ONE = 3'h1;

    // selectable events
    typedef enum logic [PEC_SEL_W-1:0] {
        PEC_EV_CYCLES     = 4'h0,
        PEC_EV_RETIRED    = 4'h1,
        PEC_EV_DC_MISS    = 4'h2,
        PEC_EV_MRQ_LIVE   = 4'h3,
        PEC_EV_ITB_MISS   = 4'h4,
        PEC_EV_DTB_MISS   = 4'h5,
        PEC_EV_BR_MISPRED = 4'h6,
        PEC_EV_BE_FLUSH   = 4'h7,
        PEC_EV_DATA_ACC   = 4'h8,
        PEC_EV_SB_DEP     = 4'h9,
        PEC_EV_INST_ACC   = 4'ha,
        PEC_EV_PIPE_FLUSH = 4'hb,
        PEC_EV_MEMORY     = 4'hc,
        PEC_EV_DEPEND     = 4'hd,
        PEC_EV_UNSTALLED  = 4'he,
        PEC_EV_NONE       = 4'hf
    } pec_ev_sel_t;

    // cycle accounting categories, one-hot, index 0 is highest priority
    typedef enum logic [PEC_CAT_N-1:0] {
        PEC_CAT_BE_FLUSH  = 8'h01,
        PEC_CAT_DATA_ACC  = 8'h02,
        PEC_CAT_SB_DEP    = 8'h04,
        PEC_CAT_REG_STACK = 8'h08,
        PEC_CAT_ISSUE_LIM = 8'h10,
        PEC_CAT_INST_ACC  = 8'h20,
        PEC_CAT_TAKEN_BR  = 8'h40,
        PEC_CAT_UNSTALLED = 8'h80
    } pec_cat_t;

endpackage : pec_pkg

`default_nettype wire

/* File: bench/pec_counters_sva.sv */
/*
 * checker for the event counters: step limits, clear, hold, cycle
 * accounting priority. assumes it is bound to pec_counters, one clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pec_counters_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] ctr_en,
    input wire logic [3:0] ctr_clr,
    input wire pec_pkg::pec_ev_sel_t ctr_sel [4],
    input wire logic [2:0] ctr_thr [4],
    input wire logic fl_br_mispred,
    input wire logic fl_exception,
    input wire logic st_mem_operand,
    input wire logic fl_fp,
    input wire logic st_taken_branch,
    input wire logic [31:0] count_q [4],
    input wire pec_pkg::pec_cat_t acct_cat_q
);
    import pec_pkg::*;
    // step bounds, modular so a wrap still passes
    localparam logic [31:0] LIM1 = 32'h0000_0001;
    localparam logic [31:0] LIM2 = 32'h0000_0002;
    localparam logic [31:0] LIM3 = 32'h0000_0003;
    localparam logic [31:0] LIM7 = 32'h0000_0007;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // flush seen, then counter 3 picks the flush category up
    sequence s_flush;
        fl_br_mispred;
    endsequence
    sequence s_be_sel;
        ctr_en[3] && !ctr_clr[3] && ctr_sel[3] == PEC_EV_BE_FLUSH
            && ctr_thr[3] == 3'h0;
    endsequence
    a_flush_counted: assert property (
        s_flush ##1 s_be_sel |=> count_q[3] == $past(count_q[3]) + LIM1)
        else $error("flush category not counted");
    a_narrow_step: assert property (
        !ctr_clr[2] && !ctr_clr[3] |=> count_q[2] - $past(count_q[2]) <= LIM3
            && count_q[3] - $past(count_q[3]) <= LIM3)
        else $error("narrow counter stepped above three");
    a_wide_step: assert property (
        !ctr_clr[0] && !ctr_clr[1] |=> count_q[0] - $past(count_q[0]) <= LIM7
            && count_q[1] - $past(count_q[1]) <= LIM7)
        else $error("wide counter stepped above seven");
    a_dc_clip: assert property (
        !ctr_clr[1] && ctr_sel[1] == PEC_EV_DC_MISS
            |=> count_q[1] - $past(count_q[1]) <= LIM2)
        else $error("data miss step above two");
    a_thr_one: assert property (
        !ctr_clr[0] && ctr_thr[0] != PEC_INC_ZERO
            |=> count_q[0] - $past(count_q[0]) <= LIM1)
        else $error("thresholded step above one");
    a_hold_idle: assert property (
        !ctr_en[0] && !ctr_clr[0] |=> $stable(count_q[0]))
        else $error("disabled counter moved");
    a_clear_zero: assert property (
        ctr_clr[1] |=> count_q[1] == PEC_CTR_RST)
        else $error("clear did not zero");
    a_cycles_one: assert property (
        ctr_en[2] && !ctr_clr[2] && ctr_sel[2] == PEC_EV_CYCLES
            && ctr_thr[2] == 3'h0 |=> count_q[2] == $past(count_q[2]) + LIM1)
        else $error("cycle event did not add one");
    a_cat_onehot: assert property (
        $onehot(acct_cat_q))
        else $error("category not one-hot");
    a_flush_wins: assert property (
        fl_br_mispred || fl_exception |=> acct_cat_q == PEC_CAT_BE_FLUSH)
        else $error("flush lost priority");
    a_mem_rank: assert property (
        st_mem_operand |=> acct_cat_q inside {PEC_CAT_BE_FLUSH,
            PEC_CAT_DATA_ACC})
        else $error("memory stall misfiled");
    a_fp_rank: assert property (
        fl_fp |=> acct_cat_q inside {PEC_CAT_BE_FLUSH, PEC_CAT_DATA_ACC,
            PEC_CAT_SB_DEP})
        else $error("fp flush misfiled");
    a_branch_lost: assert property (
        st_taken_branch |=> acct_cat_q != PEC_CAT_UNSTALLED)
        else $error("taken branch left unstalled");
endmodule : pec_counters_chk

bind pec_counters pec_counters_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .ctr_en(ctr_en), .ctr_clr(ctr_clr), .ctr_sel(ctr_sel),
    .ctr_thr(ctr_thr), .fl_br_mispred(fl_br_mispred),
    .fl_exception(fl_exception), .st_mem_operand(st_mem_operand),
    .fl_fp(fl_fp), .st_taken_branch(st_taken_branch),
    .count_q(count_q), .acct_cat_q(acct_cat_q));

`default_nettype wire

/* File: bench/pec_counters_tb.sv */
/*
 * random self-checking bench: a reference model notes expected counts
 * and category each cycle, a monitor compares them. assumes no preload.
 */
`timescale 1ns/100ps
`default_nettype none

module pec_counters_tb;
    import pec_pkg::*;
    logic sys_clk, rst_n, itb, dtb, br, p_itb, p_dtb, p_br;
    logic [3:0] en, clr;
    pec_ev_sel_t sel [4];
    logic [2:0] thr [4];
    logic [1:0] dc, p_dc;
    logic [2:0] ret, mrq, p_ret, p_mrq;
    logic [17:0] cz; // all stall and flush causes
    logic [31:0] cnt [4];
    logic [31:0] exp_c [4];
    pec_cat_t cat;
    logic [7:0] p_cat;
    logic [135:0] q [$]; // expected notes, oldest first
    integer seed = 80;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;

    pec_counters i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ctr_en(en),
        .ctr_clr(clr), .ctr_sel(sel), .ctr_thr(thr), .ev_itb_miss(itb),
        .ev_dtb_miss(dtb), .ev_br_mispred(br), .ev_dc_miss_cnt(dc),
        .ev_retired_cnt(ret), .ev_mrq_live(mrq), .fl_br_mispred(cz[0]),
        .fl_advanced_load_table(cz[1]), .fl_serialize(cz[2]),
        .fl_ctrl_spec_fail(cz[3]), .fl_memory_to_integer_unit_bypass(cz[4]),
        .fl_exception(cz[5]), .st_mem_operand(cz[6]),
        .fl_l1d_way_mispred(cz[7]), .fl_data_translation_cache(cz[8]),
        .st_nonload_operand(cz[9]), .fl_fp(cz[10]),
        .st_register_stack_engine(cz[11]), .st_issue_stop(cz[12]),
        .st_port_oversub(cz[13]), .st_issue_asym(cz[14]),
        .st_l1i_miss(cz[15]), .st_instruction_translation_buffer(cz[16]),
        .st_taken_branch(cz[17]), .count_q(cnt), .acct_cat_q(cat));

    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // hang guard, well above the planned run
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task report_and_stop();
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: %h vs %h", $time, seen, want);
        end
    endtask : check

    ////////////////////////////////////////////////////////////////////
    // latest-stage cause wins, none means unstalled
    function automatic logic [7:0] cat_of(input logic [17:0] c);
        if (|c[5:0]) return PEC_CAT_BE_FLUSH;
        if (|c[8:6]) return PEC_CAT_DATA_ACC;
        if (|c[10:9]) return PEC_CAT_SB_DEP;
        if (c[11]) return PEC_CAT_REG_STACK;
        if (|c[14:12]) return PEC_CAT_ISSUE_LIM;
        if (|c[16:15]) return PEC_CAT_INST_ACC;
        if (c[17]) return PEC_CAT_TAKEN_BR;
        return PEC_CAT_UNSTALLED;
    endfunction : cat_of

    // value of last cycle's event, before clipping
    function automatic logic [2:0] ev_val(input pec_ev_sel_t s);
        case (s)
            PEC_EV_CYCLES: return 3'h1;
            PEC_EV_RETIRED: return p_ret;
            PEC_EV_DC_MISS:
                return (p_dc == 2'h3) ? 3'h2 : {1'b0, p_dc};
            PEC_EV_MRQ_LIVE: return p_mrq;
            PEC_EV_ITB_MISS: return {2'h0, p_itb};
            PEC_EV_DTB_MISS: return {2'h0, p_dtb};
            PEC_EV_BR_MISPRED: return {2'h0, p_br};
            PEC_EV_BE_FLUSH: return {2'h0, p_cat[0]};
            PEC_EV_DATA_ACC: return {2'h0, p_cat[1]};
            PEC_EV_SB_DEP: return {2'h0, p_cat[2]};
            PEC_EV_INST_ACC: return {2'h0, p_cat[5]};
            PEC_EV_PIPE_FLUSH: return {2'h0, p_cat[0] | p_cat[6]};
            PEC_EV_MEMORY: return {2'h0, p_cat[1] | p_cat[3]};
            PEC_EV_DEPEND: return {2'h0, p_cat[2] | p_cat[4]};
            PEC_EV_UNSTALLED: return {2'h0, p_cat[5] | p_cat[7]};
            default: return 3'h0;
        endcase
    endfunction : ev_val

    // drive one cycle and note what the next edge must show
    task step(input int k);
        logic [2:0] v;
        en = k < 2 ? 4'h0 : 4'($random(seed));
        clr = (($random(seed) & 31) == 0) ? 4'($random(seed)) : 4'h0;
        {itb, dtb, br, dc} = 5'($random(seed));
        {ret, mrq} = 6'($random(seed));
        for (int j = 0; j < 18; j++)
            cz[j] = (($random(seed) & 7) == 0);
        for (int i = 0; i < 4; i++) begin
            sel[i] = pec_ev_sel_t'(4'($random(seed)));
            thr[i] = (($random(seed) & 3) == 0) ? 3'($random(seed)) : 3'h0;
            v = ev_val(sel[i]);
            if (i > 1 && v > 3'h3) v = 3'h3;
            if (thr[i] != 3'h0) v = {2'h0, v > thr[i]};
            if (clr[i]) exp_c[i] = 32'h0000_0000;
            else if (en[i]) exp_c[i] = exp_c[i] + 32'(v);
        end
        q.push_back({exp_c[0], exp_c[1], exp_c[2], exp_c[3], cat_of(cz)});
        {p_itb, p_dtb, p_br, p_dc, p_ret, p_mrq} = {itb, dtb, br, dc, ret, mrq};
        p_cat = cat_of(cz);
    endtask : step

    ////////////////////////////////////////////////////////////////////
    // monitor: one note per edge, compared where outputs are settled
    initial begin : mon
        logic [135:0] e;
        forever begin
            // a note belongs to the edge after it was made: take it there,
            // then look half a cycle on, once the outputs have moved
            @(posedge sys_clk);
            if (q.size() > 0) begin
                e = q.pop_front();
                @(negedge sys_clk);
                for (int i = 0; i < 4; i++)
                    check(cnt[i], e[135 - 32 * i -: 32]);
                check({24'h0, cat}, {24'h0, e[7:0]});
            end
        end
    end

    initial begin
        rst_n = 1'b0;
        {en, clr, itb, dtb, br, dc, ret, mrq, cz} = '0;
        {p_itb, p_dtb, p_br, p_dc, p_ret, p_mrq} = '0;
        p_cat = 8'h80;
        for (int i = 0; i < 4; i++) begin
            sel[i] = PEC_EV_NONE;
            thr[i] = 3'h0;
            exp_c[i] = 32'h0000_0000;
        end
        repeat (10) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        step(0);
        for (int k = 1; k < 2000; k++) begin
            @(posedge sys_clk);
            #1 step(k);
        end
        // one negedge past the last compare, so the verdict never races it
        repeat (3) @(negedge sys_clk);
        report_and_stop();
    end
endmodule : pec_counters_tb

`default_nettype wire
